// *** hw/dual_osc_clock_control.sv ***
// Contract
// - Normal mode instruction clock is fast oscillator divided by build-time 1..128.
// - Slow mode instruction clock is slow oscillator divided by four, always.
// - Halt bit 0 runs the fast oscillator; 1 stops it, slow keeps running.
// - Source select bit 0 picks fast oscillator, 1 picks slow oscillator.
// - CPU mode field: 00 normal, 01 sleep, 10 green, 11 reserved.
// - Slow oscillator stops only in sleep, or green on slow clock without watchdog.
// - Slow oscillator clocks the watchdog and the slow mode system clock.
// - After any reset, execution waits 2048 fast oscillator cycles.
// - Wake-up from sleep waits 32 fast oscillator cycles before execution resumes.
// - Fast oscillator enabled only when the build option selects the internal fast RC.
// - Sleep wake-up clears the sleep bit itself and resumes in normal mode.
// - Green wake-up clears the green bit itself.
// - Green wake-up returns to the clock mode green was entered from.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module dual_osc_clock_control
    import dual_osc_pkg::*;
#(
    parameter int         FCPU_DIV_LOG2   = 2,
    parameter logic       FAST_RC_OPTION  = 1'b1
)
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    // AXI4-Lite write response
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    // AXI4-Lite read data
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Oscillator ticks, one pulse per oscillator cycle
    input  wire logic        fast_osc_tick,
    input  wire logic        slow_osc_tick,
    // System events
    input  wire logic        wake_event,
    input  wire logic        watchdog_enable,
    // Oscillator enables and derived clocks
    output      logic        fast_osc_en,
    output      logic        slow_osc_en,
    output      logic        cpu_clk_tick,
    output      logic        wdt_clk_tick,
    output      logic        cpu_run
);

    generate
        if (FCPU_DIV_LOG2 < 0 || FCPU_DIV_LOG2 > 7)
        begin : g_bad_div
            $error("FCPU_DIV_LOG2 must lie in 0..7");
        end
    endgenerate

    localparam logic [6:0] DIV_MASK = 7'((8'h01 << FCPU_DIV_LOG2) - 8'h01);

    function automatic logic hits(input logic [11:0] addr, input logic [9:0] idx);
        hits = (addr[11:2] == idx);
    endfunction : hits

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic        halt_q;
    logic        src_q;
    cpu_mode_t   mode_q;
    logic        green_src_q;
    seq_state_t  state_q;
    seq_state_t  state_d;
    logic [11:0] warm_cnt_q;
    logic [6:0]  div_cnt_q;
    logic [1:0]  slow_cnt_q;

    logic        aw_held_q;
    logic        w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic        wstrb0_q;

    ////////////////////////////////////////////////////////////////////////////
    // Combinational decode

    wire aw_take    = s_axi_awvalid & s_axi_awready;
    wire w_take     = s_axi_wvalid & s_axi_wready;
    wire ar_take    = s_axi_arvalid & s_axi_arready;
    wire aw_have    = aw_held_q | aw_take;
    wire w_have     = w_held_q | w_take;
    wire do_write   = aw_have & w_have & ~s_axi_bvalid;
    wire [11:0] wr_addr  = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data  = w_held_q ? wdata_q : s_axi_wdata;
    wire        wr_strb0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
    wire wr_ctrl    = do_write & hits(wr_addr, CTRL_IDX) & wr_strb0;
    wire wr_mapped  = hits(wr_addr, CTRL_IDX) | hits(wr_addr, STAT_IDX);
    wire rd_ctrl    = hits(s_axi_araddr, CTRL_IDX);
    wire rd_stat    = hits(s_axi_araddr, STAT_IDX);

    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire warming    = (state_q == ST_WARM);
    wire running    = (state_q == ST_RUN);
    wire asleep     = (state_q == ST_SLEEP);
    wire in_green   = (state_q == ST_GREEN);
    wire fast_tick  = fast_osc_tick & fast_osc_en;
    wire slow_tick  = slow_osc_tick & slow_osc_en;
    wire warm_done  = fast_tick & (warm_cnt_q == 12'h001);

    wire [7:0] ctrl_rd = {3'h0, mode_q, src_q, halt_q, 1'b0};
    wire [7:0] stat_rd = {2'h0, state_q, slow_osc_en, fast_osc_en, warming, running};

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_WARM:
            begin
                if (warm_done)
                    state_d = ST_RUN;
            end
            ST_RUN:
            begin
                if (mode_q == MODE_SLEEP)
                    state_d = ST_SLEEP;
                else if (mode_q == MODE_GREEN)
                    state_d = ST_GREEN;
            end
            ST_SLEEP:
            begin
                if (wake_event)
                    state_d = ST_WARM;
            end
            ST_GREEN:
            begin
                if (wake_event)
                    state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_WARM;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= ST_WARM;
        else
            state_q <= state_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            warm_cnt_q <= WARM_RESET_CYC;
        else if (asleep && wake_event)
            warm_cnt_q <= WARM_WAKE_CYC;
        else if (warming && fast_tick)
            warm_cnt_q <= warm_cnt_q - 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            halt_q      <= CTRL_RESET[HALT_BIT];
            src_q       <= CTRL_RESET[SRC_BIT];
            mode_q      <= cpu_mode_t'(CTRL_RESET[MODE_HI:MODE_LO]);
            green_src_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            halt_q <= wr_data[HALT_BIT] & CTRL_WR_MASK[HALT_BIT];
            src_q  <= wr_data[SRC_BIT] & CTRL_WR_MASK[SRC_BIT];
            mode_q <= cpu_mode_t'(wr_data[MODE_HI:MODE_LO]);
        end
        // sleep wake clears bit, normal mode
        else if (asleep && wake_event)
        begin
            mode_q <= MODE_NORMAL;
            src_q  <= 1'b0;
            halt_q <= 1'b0;
        end
        else if (in_green && wake_event)
        begin
            mode_q <= MODE_NORMAL;
            src_q  <= green_src_q;
        end
        else if (running && mode_q == MODE_GREEN)
        begin
            green_src_q <= src_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator enables and clock division

    // Fast oscillator held on through warm-up, else the wait would never end
    // build option gate
    assign fast_osc_en = FAST_RC_OPTION & ~asleep & (warming | ~halt_q);

    assign slow_osc_en = ~asleep & ~(in_green & src_q & ~watchdog_enable);

    assign cpu_run = running;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt_q  <= 7'h00;
            slow_cnt_q <= 2'h0;
        end
        else
        begin
            if (fast_tick)
                div_cnt_q <= div_cnt_q + 7'h01;
            if (slow_tick)
                slow_cnt_q <= slow_cnt_q + 2'h1;
        end
    end

    wire fast_div_hit = fast_tick & ((div_cnt_q & DIV_MASK) == DIV_MASK);
    wire slow_div_hit = slow_tick & (slow_cnt_q == SLOW_DIV_LAST);
    wire cpu_tick_d   = running & (src_q ? slow_div_hit : fast_div_hit);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_clk_tick <= 1'b0;
            wdt_clk_tick <= 1'b0;
        end
        else
        begin
            cpu_clk_tick <= cpu_tick_d;
            wdt_clk_tick <= slow_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 12'h000;
            wdata_q      <= 32'h0000_0000;
            wstrb0_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                awaddr_q <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else
            begin
                aw_held_q <= aw_have;
                w_held_q  <= w_have;
                if (s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_ctrl ? ctrl_rd : (rd_stat ? stat_rd : 8'h00)};
            s_axi_rresp  <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : dual_osc_clock_control

// *** inc/dual_osc_pkg.sv ***
package dual_osc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] CTRL_IDX       = 10'h095;
    localparam logic [9:0] STAT_IDX       = 10'h096;

    // Control register field positions
    localparam int         HALT_BIT       = 1;
    localparam int         SRC_BIT        = 2;
    localparam int         MODE_LO        = 3;
    localparam int         MODE_HI        = 4;
    localparam logic [7:0] CTRL_WR_MASK   = 8'h1e;
    localparam logic [7:0] CTRL_RESET     = 8'h00;

    // Status register field positions
    localparam int         ST_RUN_BIT     = 0;
    localparam int         ST_WARM_BIT    = 1;
    localparam int         ST_FAST_BIT    = 2;
    localparam int         ST_SLOW_BIT    = 3;
    localparam int         ST_STATE_LO    = 4;

    // Warm-up lengths, in fast oscillator cycles
    localparam logic [11:0] WARM_RESET_CYC = 12'h800;
    localparam logic [11:0] WARM_WAKE_CYC  = 12'h020;

    // Last slow divider count; slow mode instruction clock is the slow oscillator divided by one more than this
    localparam logic [1:0] SLOW_DIV_LAST  = 2'h3;

    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // CPU operating mode field codes
    typedef enum logic [1:0]
    {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP  = 2'b01,
        MODE_GREEN  = 2'b10,
        MODE_RSVD   = 2'b11
    } cpu_mode_t;

    // Sequencer states
    typedef enum logic [1:0]
    {
        ST_WARM  = 2'b00,
        ST_RUN   = 2'b01,
        ST_GREEN = 2'b10,
        ST_SLEEP = 2'b11
    } seq_state_t;

endpackage : dual_osc_pkg

// *** verif/dual_osc_clock_control_tb.sv ***
`timescale 1ns/100ps
module dual_osc_clock_control_tb
    import dual_osc_pkg::*;
;
    localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        fast_tick = 1'b0, slow_tick = 1'b0, wake = 1'b0, wdog = 1'b1;
    logic        fast_en, slow_en, cpu_tick, wdt_tick, cpu_run;
    logic [7:0]  v;
    logic [31:0] d;
    int          err_count = 0, n_compared = 0, cyc = 0, seed = 55;
    int          f_cnt = 0, s_cnt = 0, f_gap = 0, s_gap = 0;
    logic        w_exp = 1'b0;

    dual_osc_clock_control #(.FCPU_DIV_LOG2(3), .FAST_RC_OPTION(1'b1)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fast_osc_tick(fast_tick), .slow_osc_tick(slow_tick), .wake_event(wake),
        .watchdog_enable(wdog), .fast_osc_en(fast_en), .slow_osc_en(slow_en),
        .cpu_clk_tick(cpu_tick), .wdt_clk_tick(wdt_tick), .cpu_run(cpu_run));

    always #5 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator ticks, gap counting between instruction ticks, timeout
    always @(posedge aclk)
    begin
        if (cpu_tick)
        begin
            f_gap = f_cnt;
            s_gap = s_cnt;
            f_cnt = 0;
            s_cnt = 0;
        end
        // Watchdog tick is the previous edge's gated slow tick; first edge has no history
        if (cyc > 0)
            chk({31'h0, wdt_tick}, {31'h0, w_exp});
        w_exp = aresetn & slow_tick & slow_en;
        f_cnt += fast_tick & fast_en;
        s_cnt += slow_tick & slow_en;
        fast_tick <= 1'($random(seed));
        slow_tick <= 1'($random(seed));
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] dt);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= dt;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(bresp, RESP_OKAY);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic ctrl_is(input logic [7:0] e);
        rd(CTRL_ADDR);
        chk(r, RESP_OKAY);
        chk(d, {24'h0, e});
    endtask : ctrl_is

    // Upper data bits are random; only the low byte may matter
    task automatic set_ctrl(input logic [7:0] x);
        wr(CTRL_ADDR, {24'($random(seed)), x});
        repeat (3) @(posedge aclk);
    endtask : set_ctrl

    task automatic warm_is(input int e);
        int n;
        n = 0;
        @(posedge aclk);
        while (!cpu_run)
        begin
            n += fast_tick & fast_en;
            @(posedge aclk);
        end
        chk(n, e);
    endtask : warm_is

    task automatic boot();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        warm_is(2048);
        ctrl_is(8'h00);
    endtask : boot

    task automatic wake_pulse();
        wake <= 1'b1;
        @(posedge aclk);
        wake <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : wake_pulse

    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        boot();
        rd(12'h100);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        repeat (4)
        begin
            v = 8'($random(seed)) & 8'he7;
            set_ctrl(v);
            ctrl_is(v & 8'h06);
            chk({fast_en, slow_en}, {~v[1], 1'b1});
        end
        set_ctrl(8'h00);
        repeat (3) @(posedge aclk iff cpu_tick);
        chk(f_gap, 8);
        set_ctrl(8'h06);
        repeat (3) @(posedge aclk iff cpu_tick);
        chk({s_gap[7:0], fast_en}, {8'h04, 1'b0});
        wdog <= 1'b0;
        set_ctrl(8'h14);
        chk({cpu_run, slow_en}, 2'b00);
        wdog <= 1'b1;
        wake_pulse();
        chk({cpu_run, slow_en}, 2'b11);
        ctrl_is(8'h04);
        set_ctrl(8'h10);
        chk(cpu_run, 1'b0);
        wake_pulse();
        ctrl_is(8'h00);
        set_ctrl(8'h18);
        chk(cpu_run, 1'b1);
        ctrl_is(8'h18);
        set_ctrl(8'h0e);
        chk({fast_en, slow_en, cpu_run}, 3'b000);
        wake <= 1'b1;
        warm_is(32);
        wake <= 1'b0;
        ctrl_is(8'h00);
        set_ctrl(8'h04);
        boot();
        tally_and_finish();
    end
endmodule : dual_osc_clock_control_tb

// *** verif/dual_osc_properties.sv ***
`timescale 1ns/100ps
module dual_osc_properties
    import dual_osc_pkg::*;
#(
    parameter logic FAST_RC_OPTION = 1'b1
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Oscillator side
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    input wire logic fast_osc_en,
    input wire logic slow_osc_en,
    input wire logic cpu_clk_tick,
    input wire logic wdt_clk_tick,
    input wire logic cpu_run
);
    logic [11:0] warm_q;
    logic        slept_q;
    logic        boot_q;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Fast ticks taken while held; both oscillators off means sleep, or green on slow clock without watchdog with fast off
    always_ff @(posedge aclk)
    begin
        if (!aresetn || cpu_run)
        begin
            warm_q  <= 12'h000;
            slept_q <= 1'b0;
        end
        else
        begin
            warm_q  <= warm_q + {11'h000, fast_osc_tick & fast_osc_en};
            slept_q <= slept_q | (!slow_osc_en & !fast_osc_en);
        end
    end
    always_ff @(posedge aclk)
        boot_q <= !aresetn | (boot_q & !cpu_run);

    ////////////////////////////////////////////////////////////////////////////////
    a_tick_in_run: assert property (cpu_clk_tick |-> $past(cpu_run))
        else $error("instruction tick outside run");
    a_wdt_follow: assert property ($past(aresetn) |->
        wdt_clk_tick == $past(slow_osc_tick && slow_osc_en))
        else $error("watchdog tick does not follow slow tick");
    a_run_slow_on: assert property (cpu_run |-> slow_osc_en)
        else $error("slow oscillator off while running");
    a_fast_option: assert property (fast_osc_en |-> FAST_RC_OPTION)
        else $error("fast oscillator on without option");
    a_reset_state: assert property (!$past(aresetn) |->
        !cpu_run && slow_osc_en && fast_osc_en == FAST_RC_OPTION)
        else $error("bad state after reset");
    a_boot_warm: assert property ($rose(cpu_run) && boot_q |-> warm_q == 12'h800)
        else $error("reset warm-up length wrong");
    a_wake_warm: assert property ($rose(cpu_run) && slept_q |-> warm_q == 12'h020)
        else $error("sleep wake warm-up length wrong");
    a_warm_fast_on: assert property (boot_q && !cpu_run |-> fast_osc_en == FAST_RC_OPTION)
        else $error("fast oscillator off during warm-up");
endmodule : dual_osc_properties

bind dual_osc_clock_control dual_osc_properties #(.FAST_RC_OPTION(FAST_RC_OPTION)) u_props (.*);
